// ---- scr_pkg.sv ----
package scr_pkg;

  // ----------------------------------------------------------------
  // Register layout
  // ----------------------------------------------------------------
  localparam logic [7:0] SCR_CFG4_RST      = 8'h03;
  localparam logic [7:0] SCR_CFG4_WMASK    = 8'h33;
  localparam logic [7:0] SCR_PROT1_RST     = 8'h00;
  localparam logic [7:0] SCR_PROT1_WMASK   = 8'h3f;
  localparam int         SCR_THR_LSB       = 4;
  localparam int         SCR_STR_LSB       = 0;
  localparam int         SCR_TO_LSB        = 4;
  localparam int         SCR_LOCK_LSB      = 0;
  localparam int         SCR_ID_ORDER_BIT  = 4;
  localparam logic [7:0] SCR_CRC_POLY      = 8'h07;
  localparam logic [7:0] SCR_CRC_SEED      = 8'hff;

  // ----------------------------------------------------------------
  // Supply-low thresholds in tenths of a volt
  // ----------------------------------------------------------------
  localparam logic [7:0] SCR_THR_LOW_DV    = 8'h3e;
  localparam logic [7:0] SCR_THR_MID_DV    = 8'h48;
  localparam logic [7:0] SCR_THR_HIGH_DV   = 8'h52;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SCR_TW            = 27;
  localparam int SCR_CLK_PERIOD_NS = 10;
  localparam int SCR_HOLD_TO0_US   = 640000;
  localparam int SCR_HOLD_TO1_US   = 320000;
  localparam int SCR_HOLD_TO2_US   = 5000;
  localparam int SCR_HOLD_TO3_US   = 1250;
  localparam int SCR_STR0_US       = 2000;
  localparam int SCR_STR1_US       = 11000;
  localparam int SCR_STR2_US       = 21000;
  localparam int SCR_STR3_US       = 31000;
  localparam int SCR_HOLD_TO0_CYC  = SCR_HOLD_TO0_US * 1000 / SCR_CLK_PERIOD_NS;
  localparam int SCR_HOLD_TO1_CYC  = SCR_HOLD_TO1_US * 1000 / SCR_CLK_PERIOD_NS;
  localparam int SCR_HOLD_TO2_CYC  = SCR_HOLD_TO2_US * 1000 / SCR_CLK_PERIOD_NS;
  localparam int SCR_HOLD_TO3_CYC  = SCR_HOLD_TO3_US * 1000 / SCR_CLK_PERIOD_NS;
  localparam int SCR_STR0_CYC      = SCR_STR0_US * 1000 / SCR_CLK_PERIOD_NS;
  localparam int SCR_STR1_CYC      = SCR_STR1_US * 1000 / SCR_CLK_PERIOD_NS;
  localparam int SCR_STR2_CYC      = SCR_STR2_US * 1000 / SCR_CLK_PERIOD_NS;
  localparam int SCR_STR3_CYC      = SCR_STR3_US * 1000 / SCR_CLK_PERIOD_NS;

endpackage

// ---- scr_tmr_if.sv ----
`timescale 1ns/1ps
interface scr_tmr_if;
  import scr_pkg::*;
  logic              run;
  logic [SCR_TW-1:0] len;
  logic              expire;
  modport ctl (output run, output len, input expire);
  modport tmr (input run, input len, output expire);
endinterface

// ---- scr_dly_timer.sv ----
`timescale 1ns/1ps
module scr_dly_timer
  import scr_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  scr_tmr_if.tmr    tif
);

  logic [SCR_TW-1:0] cnt_r;
  logic              busy_r;
  logic              done_r;
  logic              expire_r;

  // ----------------------------------------------------------------
  // Down counter, one expire pulse per run
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r    <= '0;
      busy_r   <= 1'b0;
      done_r   <= 1'b0;
      expire_r <= 1'b0;
    end else if (!tif.run) begin
      cnt_r    <= '0;
      busy_r   <= 1'b0;
      done_r   <= 1'b0;
      expire_r <= 1'b0;
    end else if (!busy_r) begin
      cnt_r    <= tif.len - SCR_TW'(1);
      busy_r   <= 1'b1;
      expire_r <= 1'b0;
    end else if (cnt_r != '0) begin
      cnt_r    <= cnt_r - SCR_TW'(1);
      expire_r <= 1'b0;
    end else begin
      expire_r <= !done_r;
      done_r   <= 1'b1;
    end
  end

  assign tif.expire = expire_r;

endmodule // scr_dly_timer

// ---- scr_cfg_regs.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Writes accepted only in config window with lock clear; both registers feed checksum.
// - Supply-low threshold code 00 6.2V, 01 7.2V, others 8.2V; resets 00.
// - Fuse zero: codes 00..11 stretch 2, 11, 21, 31 ms minimum.
// - Fuse one: codes 00..11 stretch 31, 21, 11, 2 ms minimum.
// - Hold time-out codes 00 640ms, 01 320ms, 10 5ms, 11 1.25ms; resets 00.
// - Time-out disable clear: hold state always exits to reset on expiry.
// - Disable set, fault count not above threshold: exit to reset on expiry.
// - Disable set, fault count above threshold: stay locked in hold; threshold resets 0.
// - Disable control comes from bit 5 of protection status two.
module scr_cfg_regs
  import scr_pkg::*;
#(
  parameter int unsigned HOLD_TO0_CYC = SCR_HOLD_TO0_CYC,
  parameter int unsigned HOLD_TO1_CYC = SCR_HOLD_TO1_CYC,
  parameter int unsigned HOLD_TO2_CYC = SCR_HOLD_TO2_CYC,
  parameter int unsigned HOLD_TO3_CYC = SCR_HOLD_TO3_CYC,
  parameter int unsigned STR0_CYC     = SCR_STR0_CYC,
  parameter int unsigned STR1_CYC     = SCR_STR1_CYC,
  parameter int unsigned STR2_CYC     = SCR_STR2_CYC,
  parameter int unsigned STR3_CYC     = SCR_STR3_CYC,
  parameter int unsigned TIME_DIV     = 1
)(
  input  wire logic       CLK_I,
  input  wire logic       RST_B_I,
  input  wire logic       CMD_VALID_I,
  input  wire logic       CMD_WRITE_I,
  input  wire logic       CMD_SEL_I,
  input  wire logic [7:0] CMD_WDATA_I,
  input  wire logic       CONFIG_WINDOW_STATE_I,
  input  wire logic       CFG_LOCK_I,
  input  wire logic       STRETCH_ORDER_FUSE_I,
  input  wire logic [7:0] PROTECTION_STATUS_TWO_I,
  input  wire logic [3:0] FAULT_COUNTER_I,
  input  wire logic       HOLD_STATE_I,
  input  wire logic       HOST_RESET_REQ_I,
  output logic [7:0]      RD_DATA_O,
  output logic            RD_VALID_O,
  output logic            WR_ACK_O,
  output logic            WR_REJECT_O,
  output logic [7:0]      CONFIG_CHECKSUM_O,
  output logic [7:0]      SUPPLY_LOW_THRESHOLD_DV_O,
  output logic            ID_ORDER_BIT_O,
  output logic            HOST_RESET_OUT_B_O,
  output logic            HOLD_EXIT_O,
  output logic            HOLD_LOCKED_O
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] device_config_four_r;
  logic [7:0] safety_config_one_r;
  logic       fuse_taken_r;
  logic       order_r;
  logic       wr_open;
  logic       hold_dis;
  logic       over_th;
  logic [1:0] str_idx;

  scr_tmr_if hold_tif ();
  scr_tmr_if str_tif ();

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = SCR_CRC_SEED;
    for (int i = 15; i >= 0; i--) begin
      if (c[7] ^ d[i]) begin
        c = {c[6:0], 1'b0} ^ SCR_CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction

  function automatic logic [7:0] thr_dv(input logic [1:0] code);
    case (code)
      2'b00:   return SCR_THR_LOW_DV;
      2'b01:   return SCR_THR_MID_DV;
      default: return SCR_THR_HIGH_DV;
    endcase
  endfunction

  function automatic logic [SCR_TW-1:0] str_len(input logic [1:0] idx);
    case (idx)
      2'b00:   return SCR_TW'(STR0_CYC / TIME_DIV);
      2'b01:   return SCR_TW'(STR1_CYC / TIME_DIV);
      2'b10:   return SCR_TW'(STR2_CYC / TIME_DIV);
      default: return SCR_TW'(STR3_CYC / TIME_DIV);
    endcase
  endfunction

  function automatic logic [SCR_TW-1:0] hold_len(input logic [1:0] code);
    case (code)
      2'b00:   return SCR_TW'(HOLD_TO0_CYC / TIME_DIV);
      2'b01:   return SCR_TW'(HOLD_TO1_CYC / TIME_DIV);
      2'b10:   return SCR_TW'(HOLD_TO2_CYC / TIME_DIV);
      default: return SCR_TW'(HOLD_TO3_CYC / TIME_DIV);
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Write gate and decodes
  // ----------------------------------------------------------------
  assign wr_open  = CONFIG_WINDOW_STATE_I && !CFG_LOCK_I;
  assign hold_dis = PROTECTION_STATUS_TWO_I[5];
  assign over_th  = FAULT_COUNTER_I > safety_config_one_r[SCR_LOCK_LSB +: 4];
  assign str_idx  = device_config_four_r[SCR_STR_LSB +: 2] ^ {2{order_r}};

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      device_config_four_r <= SCR_CFG4_RST;
      safety_config_one_r  <= SCR_PROT1_RST;
    end else if (CMD_VALID_I && CMD_WRITE_I && wr_open) begin
      if (!CMD_SEL_I) begin
        device_config_four_r <= CMD_WDATA_I & SCR_CFG4_WMASK;
      end else begin
        safety_config_one_r <= CMD_WDATA_I & SCR_PROT1_WMASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // Command answers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      RD_DATA_O   <= 8'h00;
      RD_VALID_O  <= 1'b0;
      WR_ACK_O    <= 1'b0;
      WR_REJECT_O <= 1'b0;
    end else begin
      RD_VALID_O  <= CMD_VALID_I && !CMD_WRITE_I;
      WR_ACK_O    <= CMD_VALID_I && CMD_WRITE_I && wr_open;
      WR_REJECT_O <= CMD_VALID_I && CMD_WRITE_I && !wr_open;
      if (CMD_VALID_I && !CMD_WRITE_I) begin
        RD_DATA_O <= CMD_SEL_I ? safety_config_one_r : device_config_four_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checksum and static outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      CONFIG_CHECKSUM_O         <= 8'h00;
      SUPPLY_LOW_THRESHOLD_DV_O <= SCR_THR_LOW_DV;
    end else begin
      CONFIG_CHECKSUM_O         <= crc8({device_config_four_r, safety_config_one_r});
      SUPPLY_LOW_THRESHOLD_DV_O <= thr_dv(device_config_four_r[SCR_THR_LSB +: 2]);
    end
  end

  // ----------------------------------------------------------------
  // Fuse capture after reset release
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      fuse_taken_r   <= 1'b0;
      order_r        <= 1'b0;
      ID_ORDER_BIT_O <= 1'b0;
    end else if (!fuse_taken_r) begin
      fuse_taken_r   <= 1'b1;
      order_r        <= STRETCH_ORDER_FUSE_I;
      ID_ORDER_BIT_O <= STRETCH_ORDER_FUSE_I;
    end
  end

  // ----------------------------------------------------------------
  // Host reset stretch
  // ----------------------------------------------------------------
  assign str_tif.run = fuse_taken_r && !HOST_RESET_REQ_I && !HOST_RESET_OUT_B_O;
  assign str_tif.len = str_len(str_idx);

  scr_dly_timer u_str_tmr (
    .clk_i   (CLK_I),
    .rst_b_i (RST_B_I),
    .tif     (str_tif)
  );

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      HOST_RESET_OUT_B_O <= 1'b0;
    end else if (HOST_RESET_REQ_I) begin
      HOST_RESET_OUT_B_O <= 1'b0;
    end else if (str_tif.expire) begin
      HOST_RESET_OUT_B_O <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Fault-hold time-out and lock
  // ----------------------------------------------------------------
  assign hold_tif.run = HOLD_STATE_I && !HOLD_LOCKED_O;
  assign hold_tif.len = hold_len(safety_config_one_r[SCR_TO_LSB +: 2]);

  scr_dly_timer u_hold_tmr (
    .clk_i   (CLK_I),
    .rst_b_i (RST_B_I),
    .tif     (hold_tif)
  );

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      HOLD_EXIT_O   <= 1'b0;
      HOLD_LOCKED_O <= 1'b0;
    end else begin
      HOLD_EXIT_O <= hold_tif.expire && (!hold_dis || !over_th);
      if (!HOLD_STATE_I) begin
        HOLD_LOCKED_O <= 1'b0;
      end else if (hold_tif.expire && hold_dis && over_th) begin
        HOLD_LOCKED_O <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_wr_gate_closed: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    CMD_VALID_I && CMD_WRITE_I && !wr_open |=> $stable(device_config_four_r)
      && $stable(safety_config_one_r) && WR_REJECT_O)
    else $error("Register changed on a rejected write");

  a_wr_open_store: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    CMD_VALID_I && CMD_WRITE_I && wr_open && CMD_SEL_I |=>
      safety_config_one_r == ($past(CMD_WDATA_I) & SCR_PROT1_WMASK) && WR_ACK_O)
    else $error("Accepted write not stored");

  a_reserved_zero: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (device_config_four_r & ~SCR_CFG4_WMASK) == 8'h00
      && (safety_config_one_r & ~SCR_PROT1_WMASK) == 8'h00)
    else $error("Reserved bit set");

  a_supply_thr_map: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    device_config_four_r[5:4] == 2'b01 ##1 device_config_four_r[5:4] == 2'b01
      |-> SUPPLY_LOW_THRESHOLD_DV_O == SCR_THR_MID_DV)
    else $error("Threshold decode wrong");

  a_stretch_order: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    fuse_taken_r && order_r && device_config_four_r[1:0] == 2'b11
      |-> str_tif.len == SCR_TW'(STR0_CYC / TIME_DIV))
    else $error("Reversed stretch order wrong");

  a_timeout_sel: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    safety_config_one_r[5:4] == 2'b01 |-> hold_tif.len == SCR_TW'(HOLD_TO1_CYC / TIME_DIV))
    else $error("Hold time-out select wrong");

  a_hold_exit: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    hold_tif.expire && (!hold_dis || FAULT_COUNTER_I <= safety_config_one_r[3:0])
      |=> HOLD_EXIT_O && !HOLD_LOCKED_O)
    else $error("Hold state did not exit on expiry");

  a_hold_lock: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    hold_tif.expire && hold_dis && over_th && HOLD_STATE_I
      |=> !HOLD_EXIT_O && HOLD_LOCKED_O)
    else $error("Hold lock not taken");

  a_host_rst_held: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    HOST_RESET_REQ_I |=> !HOST_RESET_OUT_B_O [*2])
    else $error("Host reset released too early");

  a_fuse_latched: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    fuse_taken_r |=> $stable(order_r) && ID_ORDER_BIT_O == order_r)
    else $error("Order fuse not held");

  a_lock_clears: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    !HOLD_STATE_I |=> !HOLD_LOCKED_O)
    else $error("Hold lock kept outside hold state");

  a_exit_pulse: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    HOLD_EXIT_O |=> !HOLD_EXIT_O)
    else $error("Hold exit longer than one cycle");

  a_thr_high: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    device_config_four_r[SCR_THR_LSB + 1] ##1 device_config_four_r[SCR_THR_LSB + 1]
      |-> SUPPLY_LOW_THRESHOLD_DV_O == SCR_THR_HIGH_DV)
    else $error("Upper threshold decode wrong");

  a_csum_track: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    1'b1 |=> CONFIG_CHECKSUM_O
      == crc8({$past(device_config_four_r), $past(safety_config_one_r)}))
    else $error("Checksum does not follow registers");

  a_rd_answer: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    CMD_VALID_I && !CMD_WRITE_I |=> RD_VALID_O
      && RD_DATA_O == ($past(CMD_SEL_I) ? $past(safety_config_one_r)
                                        : $past(device_config_four_r)))
    else $error("Read answer wrong");

  a_reject_no_ack: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    WR_REJECT_O |-> !WR_ACK_O && !RD_VALID_O)
    else $error("Reject paired with another answer");

endmodule // scr_cfg_regs

// ---- scr_host_model.sv ----
`timescale 1ns/1ps
module scr_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rd_data_i,
  input  wire logic       rd_valid_i,
  input  wire logic       wr_ack_i,
  input  wire logic       wr_reject_i,
  output logic            valid_o,
  output logic            write_o,
  output logic            sel_o,
  output logic [7:0]      wdata_o
);
  initial begin
    valid_o = 1'b0;
    write_o = 1'b0;
    sel_o   = 1'b0;
    wdata_o = 8'h00;
  end

  // ----------------------------------------------------------------
  // One command: strobe for one edge, answer one cycle later
  // ----------------------------------------------------------------
  task automatic xfer(input logic w, input logic s, input logic [7:0] d,
                      output logic [7:0] q, output logic ok, output logic rej);
    @(posedge clk_i);
    valid_o <= 1'b1;
    write_o <= w;
    sel_o   <= s;
    wdata_o <= d;
    @(posedge clk_i);
    valid_o <= 1'b0;
    wdata_o <= ~d;
    #1;
    q   = rd_data_i;
    ok  = w ? wr_ack_i : rd_valid_i;
    rej = wr_reject_i;
  endtask
endmodule // scr_host_model

// ---- tb_safety_config_regs.sv ----
`timescale 1ns/1ps
module tb_safety_config_regs;
  import scr_pkg::*;
  logic       clk = 1'b0, rst_b = 1'b0, win = 1'b0, lock = 1'b0, fuse = 1'b0;
  logic       hold = 1'b0, req = 1'b0;
  logic [7:0] status = 8'h00;
  logic [3:0] fault = 4'h0;
  logic       valid, write, sel, rd_valid, wr_ack, wr_rej, id_bit, rst_out_b, h_exit, h_lock;
  logic [7:0] wdata, rd_data, csum, thr_dv;
  int         n_mismatch = 0, tests_run = 0, cycles = 0;
  localparam int DIV = 20000;

  always #5 clk = ~clk;

  scr_host_model host_u (.clk_i(clk), .rd_data_i(rd_data), .rd_valid_i(rd_valid),
    .wr_ack_i(wr_ack), .wr_reject_i(wr_rej), .valid_o(valid), .write_o(write),
    .sel_o(sel), .wdata_o(wdata));

  scr_cfg_regs #(.TIME_DIV(DIV)) dut_u (
    .CLK_I(clk), .RST_B_I(rst_b), .CMD_VALID_I(valid), .CMD_WRITE_I(write), .CMD_SEL_I(sel),
    .CMD_WDATA_I(wdata), .CONFIG_WINDOW_STATE_I(win), .CFG_LOCK_I(lock),
    .STRETCH_ORDER_FUSE_I(fuse), .PROTECTION_STATUS_TWO_I(status), .FAULT_COUNTER_I(fault),
    .HOLD_STATE_I(hold), .HOST_RESET_REQ_I(req), .RD_DATA_O(rd_data), .RD_VALID_O(rd_valid),
    .WR_ACK_O(wr_ack), .WR_REJECT_O(wr_rej), .CONFIG_CHECKSUM_O(csum),
    .SUPPLY_LOW_THRESHOLD_DV_O(thr_dv), .ID_ORDER_BIT_O(id_bit),
    .HOST_RESET_OUT_B_O(rst_out_b), .HOLD_EXIT_O(h_exit), .HOLD_LOCKED_O(h_lock));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic test_done();
    if (n_mismatch == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask

  function automatic logic [7:0] crc(input logic [15:0] d);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  function automatic int str_exp(input int idx);
    case (idx)
      0:       return SCR_STR0_CYC / DIV;
      1:       return SCR_STR1_CYC / DIV;
      2:       return SCR_STR2_CYC / DIV;
      default: return SCR_STR3_CYC / DIV;
    endcase
  endfunction

  function automatic int hold_exp(input int code);
    case (code)
      0:       return SCR_HOLD_TO0_CYC / DIV;
      1:       return SCR_HOLD_TO1_CYC / DIV;
      2:       return SCR_HOLD_TO2_CYC / DIV;
      default: return SCR_HOLD_TO3_CYC / DIV;
    endcase
  endfunction

  task automatic wr(input logic s, input logic [7:0] d, input logic ok_exp);
    logic [7:0] q;
    logic       a, r;
    host_u.xfer(1'b1, s, d, q, a, r);
    chk("wr_ack", {7'h0, ok_exp}, {7'h0, a});
    chk("wr_reject", {7'h0, ~ok_exp}, {7'h0, r});
  endtask

  task automatic rd(input logic s, input logic [7:0] e);
    logic [7:0] q;
    logic       a, r;
    host_u.xfer(1'b0, s, 8'h00, q, a, r);
    chk("rd_valid", 8'h01, {7'h0, a});
    chk("rd_data", e, q);
  endtask

  task automatic do_reset(input logic f);
    int n, x;
    @(posedge clk);
    rst_b <= 1'b0;
    fuse  <= f;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    cnt_until(0, n);
    x = str_exp(f ? 0 : 3);
    chk("stretch_por", 8'h01, {7'h0, (n >= x && n <= x + 5)});
  endtask

  task automatic cnt_until(input int which, output int n);
    for (n = 1; n < 4000; n++) begin
      @(posedge clk);
      #1;
      if (which == 0 && rst_out_b === 1'b1) break;
      if (which == 1 && (h_exit === 1'b1 || h_lock === 1'b1)) break;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic reset_and_access();
    chk("id_bit", 8'h00, {7'h0, id_bit});
    chk("thr_reset", SCR_THR_LOW_DV, thr_dv);
    rd(1'b0, SCR_CFG4_RST);
    rd(1'b1, SCR_PROT1_RST);
    chk("csum_reset", crc({SCR_CFG4_RST, SCR_PROT1_RST}), csum);
    wr(1'b0, 8'h10, 1'b0);
    @(posedge clk);
    win  <= 1'b1;
    lock <= 1'b1;
    wr(1'b1, 8'h3f, 1'b0);
    rd(1'b0, SCR_CFG4_RST);
    rd(1'b1, SCR_PROT1_RST);
    @(posedge clk);
    lock <= 1'b0;
    wr(1'b0, 8'hff, 1'b1);
    wr(1'b1, 8'hff, 1'b1);
    rd(1'b0, 8'h33);
    rd(1'b1, 8'h3f);
    chk("csum_new", crc(16'h333f), csum);
  endtask

  task automatic thr_codes();
    logic [7:0] e;
    for (int c = 0; c < 4; c++) begin
      e = (c == 0) ? SCR_THR_LOW_DV : (c == 1) ? SCR_THR_MID_DV : SCR_THR_HIGH_DV;
      wr(1'b0, {2'b00, c[1:0], 4'h0}, 1'b1);
      @(posedge clk);
      #1;
      chk("thr_dv", e, thr_dv);
    end
  endtask

  task automatic stretch_all(input logic f);
    int n, x;
    for (int c = 0; c < 4; c++) begin
      wr(1'b0, {6'h00, c[1:0]}, 1'b1);
      @(posedge clk);
      req <= 1'b1;
      @(posedge clk);
      req <= 1'b0;
      cnt_until(0, n);
      x = str_exp(c ^ (f ? 3 : 0));
      chk("stretch_len", 8'h01, {7'h0, (n >= x && n <= x + 5)});
    end
  endtask

  task automatic hold_case(input int c, input logic [7:0] st, input logic [3:0] fc,
                           input logic [3:0] th, input logic lk);
    int n;
    wr(1'b1, {2'b00, c[1:0], th}, 1'b1);
    @(posedge clk);
    status <= st;
    fault  <= fc;
    hold   <= 1'b1;
    cnt_until(1, n);
    chk("hold_len", 8'h01, {7'h0, (n >= hold_exp(c) && n <= hold_exp(c) + 5)});
    chk("hold_locked", {7'h0, lk}, {7'h0, h_lock});
    chk("hold_exit", {7'h0, ~lk}, {7'h0, h_exit});
    @(posedge clk);
    hold <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("hold_release", 8'h00, {7'h0, h_lock});
  endtask

  initial begin
    do_reset(1'b0);
    reset_and_access();
    thr_codes();
    stretch_all(1'b0);
    hold_case(0, 8'hdf, 4'hf, 4'h0, 1'b0);
    hold_case(1, 8'h20, 4'h5, 4'h5, 1'b0);
    hold_case(2, 8'h20, 4'h6, 4'h5, 1'b1);
    hold_case(3, 8'h20, 4'h0, 4'h0, 1'b0);
    do_reset(1'b1);
    chk("id_bit_set", 8'h01, {7'h0, id_bit});
    rd(1'b0, SCR_CFG4_RST);
    stretch_all(1'b1);
    test_done();
  end
endmodule // tb_safety_config_regs
